// file: core_pd_pkg.sv
package core_pd_pkg;
    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [3:0] CTRL_OFFSET = 4'h0;
    localparam logic [3:0] STATUS_OFFSET = 4'h4;
    // ------------------------------------------------------------
    // control register fields
    // ------------------------------------------------------------
    localparam int CTRL_HALT_BIT = 0;
    localparam int CTRL_DOZE_BIT = 1;
    localparam int CTRL_RATIO_LSB = 2;
    localparam int CTRL_MASK_LSB = 8;
    localparam logic [1:0] RATIO_RESET = 2'h0;
    localparam logic [5:0] MASK_RESET = 6'h00;
    // ------------------------------------------------------------
    // status register fields
    // ------------------------------------------------------------
    localparam int STAT_MODE_LSB = 0;
    localparam int STAT_HALF_BIT = 2;
    localparam int STAT_GNT_BIT = 3;
    localparam int STAT_PEND_LSB = 4;
    localparam int STAT_ENTRY_BIT = 10;
    // ------------------------------------------------------------
    // misc
    // ------------------------------------------------------------
    localparam int IRQ_W = 6;
    localparam int RST_LOW_CYCLES_DEF = 4;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] MODE_ACTIVE = 2'h0;
    localparam logic [1:0] MODE_HALT = 2'h1;
    localparam logic [1:0] MODE_DOZE = 2'h2;
    localparam logic [1:0] MODE_WAIT = 2'h3;

    typedef enum logic [2:0] {
        ST_ACTIVE,
        ST_HALT_WAIT,
        ST_HALT,
        ST_DOZE_WAIT,
        ST_DOZE
    } pd_state_t;
endpackage

// file: core_reset_and_power_down_control.sv
// Design decisions made here: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// Operation
// - reset pin is synchronised internally; acts only after held low several cycles
// - during reset the pipeline stalls and all internal state returns to initial values
// - reset clears all valid and lock bits in both caches
// - reset discards pending write buffer entries
// - bus-speed strap low: bus runs at half the core rate
// - bus-speed strap high: bus runs at the core rate
// - every bus operation is timed from the bus clock enable; the grant logic here updates on every aclk cycle
// - writing 1 to halt bit enters halt: indicator on, pipeline frozen, no grants
// - halt indicator waits for own bus cycle end and bus ownership
// - in halt, write buffer keeps draining until empty
// - any irq, nmi or reset leaves halt and clears halt bit, mask ignored
// - after wake run handler for nmi or unmasked irq, else resume
// - halt indicator follows halt bit; memory interface idle during halt
// - writing 1 to doze bit enters doze; arbitration and snoop continue
// - doze indicator waits for own bus cycle end and bus ownership
// - in doze, write buffer keeps draining until empty
// - in doze, grant a bus request; drop grant when request withdrawn
// - any irq, nmi or reset leaves doze and clears doze bit, mask ignored
// - doze indicator follows doze bit; memory interface idle during doze
// - ratio field divides master clock by 1, 2, 4 or 8
// - irq and nmi inputs, active low, sampled on bus clock edges
module core_reset_and_power_down_control
    import core_pd_pkg::*;
#(
    parameter int RST_LOW_CYCLES = RST_LOW_CYCLES_DEF
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic rst_pin_n,
    input wire logic half_bus_n,
    input wire logic [IRQ_W-1:0] irq_n,
    input wire logic nmi_n,
    input wire logic master_req_n,
    input wire logic bus_busy,
    input wire logic wbuf_empty,
    output logic master_gnt_n,
    output logic core_rst,
    output logic pipe_freeze,
    output logic cache_inv_all,
    output logic wbuf_discard,
    output logic bus_clk_en,
    output logic halt_ind,
    output logic doze_ind,
    output logic mem_idle,
    output logic wbuf_drain,
    output logic wake_handler,
    output logic wake_resume,
    output logic proc_clk_en,
    output logic proc_clk_lvl
);
    // ------------------------------------------------------------
    // reset pin synchroniser and low-sample counter
    // ------------------------------------------------------------
    logic rst_s1_ff, rst_s2_ff, core_rst_ff;
    logic [7:0] low_cnt_ff;
    wire low_full = (low_cnt_ff == 8'(RST_LOW_CYCLES - 1));

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rst_s1_ff <= 1'b1;
            rst_s2_ff <= 1'b1;
            low_cnt_ff <= 8'h00;
            core_rst_ff <= 1'b0;
        end else begin
            rst_s1_ff <= rst_pin_n;
            rst_s2_ff <= rst_s1_ff;
            // short glitches restart the count, so they never reset the core
            low_cnt_ff <= rst_s2_ff ? 8'h00 : (low_full ? low_cnt_ff : low_cnt_ff + 8'h01);
            core_rst_ff <= !rst_s2_ff && (low_full || core_rst_ff);
        end
    end

    wire rst_i = !aresetn || core_rst_ff;
    assign core_rst = core_rst_ff;
    assign cache_inv_all = core_rst_ff;
    assign wbuf_discard = core_rst_ff;

    // ------------------------------------------------------------
    // bus-speed strap and bus clock enable
    // ------------------------------------------------------------
    logic half_ff, strap_taken_ff, bus_ph_ff;
    always_ff @(posedge aclk) begin
        if (rst_i) begin
            half_ff <= 1'b0;
            strap_taken_ff <= 1'b0;
            bus_ph_ff <= 1'b0;
        end else begin
            // strap caught once after release; later changes are not followed
            if (!strap_taken_ff) begin
                half_ff <= !half_bus_n;
                strap_taken_ff <= 1'b1;
            end
            bus_ph_ff <= half_ff ? !bus_ph_ff : 1'b1;
        end
    end
    assign bus_clk_en = strap_taken_ff && (half_ff ? bus_ph_ff : 1'b1);

    // ------------------------------------------------------------
    // interrupt sampling on bus clock edges
    // ------------------------------------------------------------
    logic [IRQ_W-1:0] irq_act_ff;
    logic nmi_prev_ff, nmi_edge_ff;
    always_ff @(posedge aclk) begin
        if (rst_i) begin
            irq_act_ff <= '0;
            nmi_prev_ff <= 1'b0;
            nmi_edge_ff <= 1'b0;
        end else if (bus_clk_en) begin
            irq_act_ff <= ~irq_n;
            nmi_prev_ff <= !nmi_n;
            nmi_edge_ff <= !nmi_n && !nmi_prev_ff;
        end else begin
            nmi_edge_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------
    logic aw_got_ff, w_got_ff, bvalid_ff, rvalid_ff;
    logic [3:0] awaddr_ff, wstrb_ff;
    logic [31:0] wdata_ff, rdata_ff;
    logic [1:0] bresp_ff, rresp_ff;
    logic ctrl_halt_ff, ctrl_doze_ff;
    logic [1:0] ratio_ff;
    logic [IRQ_W-1:0] mask_ff;
    pd_state_t state_ff, nxt_state;

    assign s_axi_awready = !aw_got_ff && !bvalid_ff;
    assign s_axi_wready = !w_got_ff && !bvalid_ff;
    assign s_axi_arready = !rvalid_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;

    wire aw_now = aw_got_ff || (s_axi_awvalid && s_axi_awready);
    wire w_now = w_got_ff || (s_axi_wvalid && s_axi_wready);
    wire [3:0] wr_addr = aw_got_ff ? awaddr_ff : s_axi_awaddr;
    wire [31:0] wr_data = w_got_ff ? wdata_ff : s_axi_wdata;
    // strobes belong to the data beat and are held with it
    wire [3:0] wr_strb = w_got_ff ? wstrb_ff : s_axi_wstrb;
    wire wr_fire = aw_now && w_now && !bvalid_ff;
    wire wr_ctrl = wr_fire && (wr_addr == CTRL_OFFSET);
    wire wr_ok = wr_ctrl || (wr_fire && wr_addr == STATUS_OFFSET);
    wire rd_fire = s_axi_arvalid && s_axi_arready;

    wire [31:0] ctrl_word = {18'h0, mask_ff, 4'h0, ratio_ff, ctrl_doze_ff, ctrl_halt_ff};
    wire [1:0] mode_code = (state_ff == ST_HALT) ? MODE_HALT :
                           (state_ff == ST_DOZE) ? MODE_DOZE :
                           (state_ff == ST_ACTIVE) ? MODE_ACTIVE : MODE_WAIT;
    wire [31:0] stat_word = {21'h0, (state_ff == ST_HALT_WAIT || state_ff == ST_DOZE_WAIT),
                             irq_act_ff, !master_gnt_n, half_ff, mode_code};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            rvalid_ff <= 1'b0;
            awaddr_ff <= 4'h0;
            wstrb_ff <= 4'h0;
            wdata_ff <= 32'h0;
            rdata_ff <= 32'h0;
            bresp_ff <= RESP_OKAY;
            rresp_ff <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awaddr_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end
            aw_got_ff <= aw_now && !wr_fire;
            w_got_ff <= w_now && !wr_fire;
            if (wr_fire) begin
                bvalid_ff <= 1'b1;
                bresp_ff <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_ff <= 1'b0;
            end
            if (rd_fire) begin
                rvalid_ff <= 1'b1;
                rdata_ff <= (s_axi_araddr == CTRL_OFFSET) ? ctrl_word :
                            (s_axi_araddr == STATUS_OFFSET) ? stat_word : 32'h0;
                rresp_ff <= (s_axi_araddr == CTRL_OFFSET || s_axi_araddr == STATUS_OFFSET) ?
                            RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rready) begin
                rvalid_ff <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // power-down state machine
    // ------------------------------------------------------------
    wire sleeping = (state_ff == ST_HALT) || (state_ff == ST_DOZE);
    wire wake = |irq_act_ff || nmi_edge_ff; // mask not consulted for wake
    wire own_bus = master_gnt_n;
    wire bus_free = !bus_busy && own_bus;
    wire set_halt = wr_ctrl && wr_strb[0] && wr_data[CTRL_HALT_BIT] && (state_ff == ST_ACTIVE);
    wire set_doze = wr_ctrl && wr_strb[0] && wr_data[CTRL_DOZE_BIT] && (state_ff == ST_ACTIVE) && !set_halt;

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_ACTIVE: begin
                if (set_halt) begin
                    nxt_state = ST_HALT_WAIT;
                end else if (set_doze) begin
                    nxt_state = ST_DOZE_WAIT;
                end
            end
            ST_HALT_WAIT: begin
                if (wake) begin
                    nxt_state = ST_ACTIVE;
                end else if (bus_free) begin
                    nxt_state = ST_HALT;
                end
            end
            ST_DOZE_WAIT: begin
                if (wake) begin
                    nxt_state = ST_ACTIVE;
                end else if (bus_free) begin
                    nxt_state = ST_DOZE;
                end
            end
            ST_HALT: begin
                if (wake) begin
                    nxt_state = ST_ACTIVE;
                end
            end
            ST_DOZE: begin
                if (wake) begin
                    nxt_state = ST_ACTIVE;
                end
            end
        endcase
    end

    logic wake_h_ff, wake_r_ff;
    always_ff @(posedge aclk) begin
        if (rst_i) begin
            state_ff <= ST_ACTIVE;
            ctrl_halt_ff <= 1'b0;
            ctrl_doze_ff <= 1'b0;
            ratio_ff <= RATIO_RESET;
            mask_ff <= MASK_RESET;
            wake_h_ff <= 1'b0;
            wake_r_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            // a wake clears the bits only outside ST_ACTIVE, so a write with a wake in the same cycle still sets them
            ctrl_halt_ff <= (ctrl_halt_ff || set_halt) && !(wake && state_ff != ST_ACTIVE);
            ctrl_doze_ff <= (ctrl_doze_ff || set_doze) && !(wake && state_ff != ST_ACTIVE);
            if (wr_ctrl && wr_strb[0]) begin
                ratio_ff <= wr_data[CTRL_RATIO_LSB +: 2];
            end
            if (wr_ctrl && wr_strb[1]) begin
                mask_ff <= wr_data[CTRL_MASK_LSB +: IRQ_W];
            end
            wake_h_ff <= wake && sleeping && (nmi_edge_ff || |(irq_act_ff & mask_ff));
            wake_r_ff <= wake && sleeping && !(nmi_edge_ff || |(irq_act_ff & mask_ff));
        end
    end

    assign halt_ind = (state_ff == ST_HALT) && ctrl_halt_ff;
    assign doze_ind = (state_ff == ST_DOZE) && ctrl_doze_ff;
    assign pipe_freeze = core_rst_ff || sleeping;
    assign wbuf_drain = sleeping && !wbuf_empty;
    assign mem_idle = core_rst_ff || (sleeping && wbuf_empty);
    assign wake_handler = wake_h_ff;
    assign wake_resume = wake_r_ff;

    // ------------------------------------------------------------
    // bus arbitration
    // ------------------------------------------------------------
    logic gnt_ff;
    wire no_new_gnt = (state_ff == ST_HALT) || (state_ff == ST_HALT_WAIT);
    always_ff @(posedge aclk) begin
        if (rst_i) begin
            gnt_ff <= 1'b0;
        end else if (gnt_ff) begin
            gnt_ff <= !master_req_n;
        end else begin
            gnt_ff <= !master_req_n && !bus_busy && !no_new_gnt;
        end
    end
    assign master_gnt_n = !gnt_ff;

    // ------------------------------------------------------------
    // processor clock divider
    // ------------------------------------------------------------
    function automatic logic [3:0] div_len(input logic [1:0] r);
        div_len = 4'h1 << r;
    endfunction

    logic [1:0] ratio_q_ff;
    logic [2:0] div_cnt_ff;
    wire [3:0] cur_len = div_len(ratio_q_ff);
    wire div_wrap = ({1'b0, div_cnt_ff} == cur_len - 4'h1);
    always_ff @(posedge aclk) begin
        if (rst_i) begin
            ratio_q_ff <= RATIO_RESET;
            div_cnt_ff <= 3'h0;
        end else if (div_wrap) begin
            div_cnt_ff <= 3'h0;
            ratio_q_ff <= ratio_ff;
        end else begin
            div_cnt_ff <= div_cnt_ff + 3'h1;
        end
    end
    // the last count of every period sits in the low half, except at ratio 0 where the level stays high
    assign proc_clk_en = (div_cnt_ff == 3'h0);
    assign proc_clk_lvl = (ratio_q_ff == 2'h0) || ({1'b0, div_cnt_ff} < (cur_len >> 1));

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    localparam int RST_N = RST_LOW_CYCLES;

    property p_rst_effects;
        @(posedge aclk) disable iff (!aresetn)
        core_rst |-> (pipe_freeze && cache_inv_all && wbuf_discard && mem_idle) ##1 state_ff == ST_ACTIVE;
    endproperty
    a_rst_effects: assert property (p_rst_effects) else $error("reset effects missing");

    property p_rst_count;
        @(posedge aclk) disable iff (!aresetn)
        $rose(core_rst_ff) |-> $past(low_cnt_ff) == 8'(RST_N - 1) && !$past(rst_s2_ff);
    endproperty
    a_rst_count: assert property (p_rst_count) else $error("reset applied before count");

    property p_half_rate;
        @(posedge aclk) disable iff (rst_i)
        half_ff && bus_clk_en |=> !bus_clk_en ##1 bus_clk_en;
    endproperty
    a_half_rate: assert property (p_half_rate) else $error("half bus rate wrong");

    property p_full_rate;
        @(posedge aclk) disable iff (rst_i)
        strap_taken_ff && !half_ff |-> bus_clk_en;
    endproperty
    a_full_rate: assert property (p_full_rate) else $error("full bus rate wrong");

    property p_halt_entry;
        @(posedge aclk) disable iff (rst_i)
        $rose(halt_ind) |-> !$past(bus_busy) && $past(master_gnt_n);
    endproperty
    a_halt_entry: assert property (p_halt_entry) else $error("halt before bus free");

    property p_halt_no_gnt;
        @(posedge aclk) disable iff (rst_i)
        state_ff == ST_HALT && master_gnt_n |=> master_gnt_n;
    endproperty
    a_halt_no_gnt: assert property (p_halt_no_gnt) else $error("grant given in halt");

    property p_doze_gnt;
        @(posedge aclk) disable iff (rst_i)
        doze_ind && !master_req_n && !bus_busy |=> !master_gnt_n;
    endproperty
    a_doze_gnt: assert property (p_doze_gnt) else $error("no grant in doze");

    property p_gnt_drop;
        @(posedge aclk) disable iff (rst_i)
        !master_gnt_n && master_req_n |=> master_gnt_n;
    endproperty
    a_gnt_drop: assert property (p_gnt_drop) else $error("grant held after release");

    property p_halt_wake;
        @(posedge aclk) disable iff (rst_i)
        halt_ind && (|irq_act_ff || nmi_edge_ff) |=> !halt_ind && !ctrl_halt_ff && (wake_handler ^ wake_resume);
    endproperty
    a_halt_wake: assert property (p_halt_wake) else $error("halt wake failed");

    property p_doze_wake;
        @(posedge aclk) disable iff (rst_i)
        doze_ind && (|irq_act_ff || nmi_edge_ff) |=> !doze_ind && !ctrl_doze_ff;
    endproperty
    a_doze_wake: assert property (p_doze_wake) else $error("doze wake failed");

    property p_idle;
        @(posedge aclk) disable iff (rst_i)
        (halt_ind || doze_ind) && wbuf_empty |-> mem_idle && !wbuf_drain;
    endproperty
    a_idle: assert property (p_idle) else $error("memory interface not idle");

    property p_ratio_switch;
        @(posedge aclk) disable iff (rst_i)
        $changed(ratio_q_ff) |-> $past(div_wrap) && div_cnt_ff == 3'h0;
    endproperty
    a_ratio_switch: assert property (p_ratio_switch) else $error("ratio switched mid period");

    c_halt: cover property (@(posedge aclk) disable iff (rst_i) $rose(halt_ind));
    c_doze_gnt: cover property (@(posedge aclk) disable iff (rst_i) doze_ind && !master_gnt_n);
    c_resume: cover property (@(posedge aclk) disable iff (rst_i) wake_resume);
    c_div8: cover property (@(posedge aclk) disable iff (rst_i) ratio_q_ff == 2'h3 && proc_clk_en);
endmodule

// file: far_side_model.sv
`timescale 1ns/1ps
module far_side_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic want_bus,
    input wire logic load_stb,
    input wire logic [3:0] load_cnt,
    input wire logic wbuf_drain,
    input wire logic bus_clk_en,
    output logic master_req_n,
    output logic wbuf_empty
);
    // ------------------------------------------------------------
    // external master and write buffer stand-in
    // ------------------------------------------------------------
    logic [3:0] pend_ff;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            master_req_n <= 1'b1;
            pend_ff <= 4'h0;
        end else begin
            master_req_n <= !want_bus;
            if (load_stb) begin
                pend_ff <= load_cnt;
            end else if (wbuf_drain && bus_clk_en && pend_ff != 4'h0) begin
                pend_ff <= pend_ff - 4'h1;
            end
        end
    end
    assign wbuf_empty = (pend_ff == 4'h0);
endmodule

// file: core_reset_and_power_down_control_tb.sv
`timescale 1ns/1ps
module core_reset_and_power_down_control_tb;
    import core_pd_pkg::*;
    localparam int RLC = 2;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hf, load_cnt = 4'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic awready, wready, bvalid, arready, rvalid, gnt_n, req_n, wbuf_empty, core_rst, pipe_freeze;
    logic cache_inv, wbuf_disc, bus_clk_en, halt_ind, doze_ind, mem_idle, wbuf_drain, wk_h, wk_r, pce, pcl;
    logic [1:0] bresp, rresp, resp;
    logic rst_pin_n = 1, half_bus_n = 0, nmi_n = 1, bus_busy = 0, want_bus = 0, load_stb = 0, seen;
    logic [IRQ_W-1:0] irq_n = 6'h3f;
    logic [31:0] d;
    int failures = 0, checked = 0, cycles = 0, n, h;

    always #5 aclk = ~aclk;

    core_reset_and_power_down_control #(.RST_LOW_CYCLES(RLC)) dut_u (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .rst_pin_n(rst_pin_n), .half_bus_n(half_bus_n), .irq_n(irq_n), .nmi_n(nmi_n),
        .master_req_n(req_n), .bus_busy(bus_busy), .wbuf_empty(wbuf_empty), .master_gnt_n(gnt_n),
        .core_rst(core_rst), .pipe_freeze(pipe_freeze), .cache_inv_all(cache_inv), .wbuf_discard(wbuf_disc),
        .bus_clk_en(bus_clk_en), .halt_ind(halt_ind), .doze_ind(doze_ind), .mem_idle(mem_idle),
        .wbuf_drain(wbuf_drain), .wake_handler(wk_h), .wake_resume(wk_r), .proc_clk_en(pce),
        .proc_clk_lvl(pcl));

    far_side_model far_u (.aclk(aclk), .aresetn(aresetn), .want_bus(want_bus), .load_stb(load_stb),
        .load_cnt(load_cnt), .wbuf_drain(wbuf_drain), .bus_clk_en(bus_clk_en), .master_req_n(req_n),
        .wbuf_empty(wbuf_empty));

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
        end while (bvalid !== 1'b1);
        resp = bresp;
        bready <= 0;
        @(posedge aclk);
    endtask

    task automatic rd(input logic [3:0] a);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 0;
        end while (rvalid !== 1'b1);
        d = rdata;
        resp = rresp;
        rready <= 0;
        @(posedge aclk);
    endtask

    // strap only moves while the block is held in reset
    task automatic bus_reset(input logic strap);
        aresetn <= 0;
        half_bus_n <= strap;
        repeat (16) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        n = 0;
        repeat (16) begin
            @(posedge aclk);
            n += bus_clk_en;
        end
    endtask

    task automatic t_speed();
        bus_reset(1'b0);
        chk("half rate enables", 8, n);
        bus_reset(1'b1);
        chk("full rate enables", 16, n);
    endtask

    task automatic t_divider();
        for (int c = 3; c >= 0; c--) begin
            wr(CTRL_OFFSET, 32'(c) << CTRL_RATIO_LSB);
            repeat (16) @(posedge aclk);
            n = 0;
            h = 0;
            repeat (32) begin
                @(posedge aclk);
                n += pce;
                h += pcl;
            end
            chk("proc clock pulses", 32 >> c, n);
            chk("proc clock high", (c == 0) ? 32 : 16, h);
        end
        wr(CTRL_OFFSET, 32'h0000000c);
    endtask

    task automatic t_pin_reset();
        rst_pin_n <= 0;
        n = 0;
        do begin
            @(posedge aclk);
            #1 n++;
        end while (core_rst !== 1'b1 && n < 20);
        chk("reset delay", RLC + 2, n);
        chk("freeze inv discard", 3'b111, {pipe_freeze, cache_inv, wbuf_disc});
        @(posedge aclk);
        rst_pin_n <= 1;
        repeat (6) @(posedge aclk);
        chk("core reset released", 0, core_rst);
        rd(CTRL_OFFSET);
        chk("ctrl after reset", 0, d);
    endtask

    task automatic t_halt();
        bus_busy <= 1;
        wr(CTRL_OFFSET, 32'h00000001);
        load_stb <= 1;
        load_cnt <= 4'h3;
        repeat (4) @(posedge aclk);
        chk("halt held by bus cycle", 0, halt_ind);
        load_stb <= 0;
        bus_busy <= 0;
        want_bus <= 1;
        repeat (4) @(posedge aclk);
        chk("halt entered", 3'b110, {halt_ind, pipe_freeze, mem_idle});
        chk("draining", 1, wbuf_drain);
        repeat (12) @(posedge aclk);
        chk("no grant in halt, idle bus", 2'b11, {gnt_n, mem_idle});
        want_bus <= 0;
        irq_n <= 6'h3e;
        n = 0;
        seen = 0;
        do begin
            @(posedge aclk);
            n++;
            seen |= wk_r;
        end while ((halt_ind === 1'b1 || n < 4) && n < 20);
        irq_n <= 6'h3f;
        chk("masked wake resumes", 1, seen);
        rd(CTRL_OFFSET);
        chk("halt bit cleared", 0, d[CTRL_HALT_BIT]);
    endtask

    task automatic t_doze();
        wr(CTRL_OFFSET, 32'h00000102);
        repeat (4) @(posedge aclk);
        chk("doze entered, bus idle", 2'b11, {doze_ind, mem_idle});
        want_bus <= 1;
        repeat (6) @(posedge aclk);
        chk("grant in doze", 0, gnt_n);
        rd(STATUS_OFFSET);
        chk("status in doze", {1'b1, 1'b0, MODE_DOZE}, d[3:0]);
        want_bus <= 0;
        repeat (6) @(posedge aclk);
        chk("grant dropped", 2'b11, {gnt_n, doze_ind});
        nmi_n <= 0;
        n = 0;
        seen = 0;
        do begin
            @(posedge aclk);
            n++;
            seen |= wk_h;
        end while ((doze_ind === 1'b1 || n < 4) && n < 20);
        nmi_n <= 1;
        chk("nmi wake runs handler", 1, seen);
        rd(CTRL_OFFSET);
        chk("doze bit cleared", 0, d[CTRL_DOZE_BIT]);
    endtask

    task automatic t_bus_errors();
        rd(4'h8);
        chk("unmapped read resp", RESP_SLVERR, resp);
        chk("unmapped read data", 0, d);
        wr(STATUS_OFFSET, 32'h00000003);
        chk("status write", RESP_OKAY, resp);
    endtask

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    always @(posedge aclk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            wrap_up();
        end
    end

    initial begin
        t_speed();
        t_divider();
        t_pin_reset();
        t_halt();
        t_doze();
        t_bus_errors();
        wrap_up();
    end
endmodule
